// ===== core/mon_link_defines.svh
// Notes on behaviour
// - Blank reset vector means both bytes all ones
// - High-voltage entry bypasses the clock divider
// - Low-voltage entry ignores port B entry pins
// - Blank-vector entry adds one extra reset cycle
// - Programmed vector: entry only with high voltage
// - Blank-vector entry: watchdog always disabled
// - High-voltage entry: watchdog off while voltage held
// - Entry latched on reset pin rising edge
// - Eight security bytes, then ten-bit break sent
// - Monitor mode uses monitor-page vectors
// - Blank-vector monitor exits only on power-on reset
// - NRZ format, same rate both directions
// - Start plus nine low bits is break
// - Break: two bit times high, then echo
// - Bit period is 1024 input clock periods
// - Ground-level blank entry enables the PLL
// - Supply-level blank entry: bus clock input/4
`ifndef MON_LINK_DEFINES_SVH
`define MON_LINK_DEFINES_SVH

// ==========================================================
// Entry and vectors
`define MON_BLANK_BYTE 8'hFF
`define MON_RST_VEC_USER 16'hFFFE
`define MON_RST_VEC_MON 16'hFEFE
`define MON_BRK_VEC_USER 16'hFFFC
`define MON_BRK_VEC_MON 16'hFEFC

// ==========================================================
// Serial timing, counted in input clock periods, bits and bytes
`define MON_BIT_DIV 1024
`define MON_SEC_LAST 4'h7
`define MON_BREAK_LAST 4'h9
`define MON_HOLD_LAST 4'h1
`define MON_FRAME_LAST 4'h9

`endif

// ===== core/mon_link_pkg.sv
package mon_link_pkg;

	typedef enum logic [5:0] {
		LINK_OFF    = 6'h01,
		LINK_SECURE = 6'h02,
		LINK_BRK_TX = 6'h04,
		LINK_READY  = 6'h08,
		LINK_HOLD   = 6'h10,
		LINK_ECHO   = 6'h20
	} link_state_e;

	typedef logic [3:0] bit_cnt_t;

endpackage

// ===== core/monitor_entry_link.sv
`timescale 1ns/1ps
`include "mon_link_defines.svh"

module monitor_entry_link
	import mon_link_pkg::*;
#(
	parameter int BIT_DIV = `MON_BIT_DIV
) (
	// Clock, reset, enable
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire logic i_clk_en,
	// Power-on reset and entry pins
	input wire logic i_por,
	input wire logic i_ext_reset_n,
	input wire logic i_irq_test_high_voltage,
	input wire logic i_irq_level,
	input wire logic i_rst_test_high_voltage,
	input wire logic i_port_b0,
	input wire logic i_port_b1,
	input wire logic i_comm_select_pin,
	input wire logic [7:0] i_reset_vector_hi,
	input wire logic [7:0] i_reset_vector_lo,
	// Oscillator input period strobe
	input wire logic i_osc_tick,
	// Mode and clock control
	output logic o_monitor_mode,
	output logic o_blank_entry,
	output logic o_serial_mode,
	output logic o_watchdog_disable,
	output logic o_divider_bypass,
	output logic o_pll_enable,
	output logic o_bus_div4,
	output logic o_extra_reset,
	// Vector addresses
	output logic [15:0] o_reset_vector_addr,
	output logic [15:0] o_break_vector_addr,
	output logic [15:0] o_software_interrupt_vector_addr,
	// Monitor data pin
	input wire logic i_monitor_data_pin,
	output logic o_monitor_data_pin,
	output logic o_monitor_data_pin_oe,
	// Received data
	output logic o_link_ready,
	output logic [7:0] o_rx_data,
	output logic o_rx_valid,
	output logic o_break_seen
);

	localparam int TW = $clog2(BIT_DIV);
	localparam logic [TW-1:0] TICK_LAST = TW'(BIT_DIV - 1);
	localparam logic [TW-1:0] TICK_HALF = TW'(BIT_DIV / 2 - 1);

	// ==========================================================
	// Entry latch
	logic mon_q, mon_d;
	logic blank_q, blank_d;
	logic hv_q, hv_d;
	logic pll_q, pll_d;
	logic div4_q, div4_d;
	logic serial_q, serial_d;
	logic xrst_q, xrst_d;
	logic xdone_q, xdone_d;
	logic rstp_q, rstp_d;
	logic wd_q, wd_d;
	logic vec_blank;

	assign vec_blank = (i_reset_vector_hi == `MON_BLANK_BYTE) &&
		(i_reset_vector_lo == `MON_BLANK_BYTE);

	always_comb begin
		mon_d = mon_q;
		blank_d = blank_q;
		hv_d = hv_q;
		pll_d = pll_q;
		div4_d = div4_q;
		serial_d = serial_q;
		xrst_d = 1'b0;
		xdone_d = xdone_q;
		rstp_d = i_ext_reset_n;
		if (i_por) begin
			mon_d = 1'b0;
			blank_d = 1'b0;
			hv_d = 1'b0;
			pll_d = 1'b0;
			div4_d = 1'b0;
			xdone_d = 1'b0;
		end else if (i_ext_reset_n && !rstp_q && !(mon_q && blank_q)) begin
			// Port B only checked on the high-voltage path
			if (i_irq_test_high_voltage) begin
				mon_d = i_port_b0 && !i_port_b1;
				hv_d = i_port_b0 && !i_port_b1;
				blank_d = 1'b0;
				pll_d = 1'b0;
				div4_d = 1'b0;
			end else begin
				mon_d = vec_blank;
				blank_d = vec_blank;
				hv_d = 1'b0;
				pll_d = vec_blank && !i_irq_level;
				div4_d = vec_blank && i_irq_level;
				if (vec_blank && !xdone_q) begin
					xrst_d = 1'b1;
					xdone_d = 1'b1;
				end
			end
			serial_d = !i_comm_select_pin;
		end
		// Watchdog held off whenever reset pin is low
		wd_d = !i_ext_reset_n ||
			(mon_d && (blank_d ||
			(hv_d && (i_irq_test_high_voltage || i_rst_test_high_voltage))));
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			mon_q <= 1'b0;
			blank_q <= 1'b0;
			hv_q <= 1'b0;
			pll_q <= 1'b0;
			div4_q <= 1'b0;
			serial_q <= 1'b0;
			xrst_q <= 1'b0;
			xdone_q <= 1'b0;
			// Idle pin level, so leaving reset is no false edge
			rstp_q <= 1'b1;
			wd_q <= 1'b1;
		end else if (i_clk_en) begin
			mon_q <= mon_d;
			blank_q <= blank_d;
			hv_q <= hv_d;
			pll_q <= pll_d;
			div4_q <= div4_d;
			serial_q <= serial_d;
			xrst_q <= xrst_d;
			xdone_q <= xdone_d;
			rstp_q <= rstp_d;
			wd_q <= wd_d;
		end
	end

	assign o_monitor_mode = mon_q;
	assign o_blank_entry = blank_q;
	assign o_serial_mode = serial_q;
	assign o_watchdog_disable = wd_q;
	assign o_divider_bypass = mon_q && hv_q;
	assign o_pll_enable = mon_q && pll_q;
	assign o_bus_div4 = mon_q && div4_q;
	assign o_extra_reset = xrst_q;
	assign o_reset_vector_addr = mon_q ? `MON_RST_VEC_MON : `MON_RST_VEC_USER;
	assign o_break_vector_addr = mon_q ? `MON_BRK_VEC_MON : `MON_BRK_VEC_USER;
	assign o_software_interrupt_vector_addr = mon_q ? `MON_BRK_VEC_MON :
		`MON_BRK_VEC_USER;

	// ==========================================================
	// Receiver
	logic rx_busy_q, rx_busy_d;
	logic [TW-1:0] rx_tick_q, rx_tick_d;
	bit_cnt_t rx_bit_q, rx_bit_d;
	logic [7:0] rx_shift_q, rx_shift_d;
	logic [7:0] rx_data_q, rx_data_d;
	logic rx_done_q, rx_done_d;
	logic rx_brk_q, rx_brk_d;
	logic rx_prev_q, rx_prev_d;
	logic link_drive;

	always_comb begin
		rx_busy_d = rx_busy_q;
		rx_tick_d = rx_tick_q;
		rx_bit_d = rx_bit_q;
		rx_shift_d = rx_shift_q;
		rx_data_d = rx_data_q;
		rx_done_d = 1'b0;
		rx_brk_d = 1'b0;
		rx_prev_d = i_monitor_data_pin;
		if (link_drive) begin
			// Half duplex: own transmission is not received
			rx_busy_d = 1'b0;
		end else if (!rx_busy_q) begin
			if (rx_prev_q && !i_monitor_data_pin) begin
				rx_busy_d = 1'b1;
				rx_tick_d = TICK_HALF;
				rx_bit_d = 4'h0;
			end
		end else if (i_osc_tick) begin
			if (rx_tick_q != '0) begin
				rx_tick_d = rx_tick_q - 1'b1;
			end else begin
				rx_tick_d = TICK_LAST;
				rx_bit_d = rx_bit_q + 1'b1;
				if (rx_bit_q == 4'h0) begin
					rx_busy_d = !i_monitor_data_pin;
				end else if (rx_bit_q == `MON_FRAME_LAST) begin
					rx_busy_d = 1'b0;
					if (i_monitor_data_pin) begin
						rx_done_d = 1'b1;
						rx_data_d = rx_shift_q;
					end else if (rx_shift_q == '0) begin
						rx_brk_d = 1'b1;
					end
				end else begin
					rx_shift_d = {i_monitor_data_pin, rx_shift_q[7:1]};
				end
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			rx_busy_q <= 1'b0;
			rx_tick_q <= '0;
			rx_bit_q <= 4'h0;
			rx_shift_q <= 8'h00;
			rx_data_q <= 8'h00;
			rx_done_q <= 1'b0;
			rx_brk_q <= 1'b0;
			rx_prev_q <= 1'b1;
		end else if (i_clk_en) begin
			rx_busy_q <= rx_busy_d;
			rx_tick_q <= rx_tick_d;
			rx_bit_q <= rx_bit_d;
			rx_shift_q <= rx_shift_d;
			rx_data_q <= rx_data_d;
			rx_done_q <= rx_done_d;
			rx_brk_q <= rx_brk_d;
			rx_prev_q <= rx_prev_d;
		end
	end

	// ==========================================================
	// Link sequencer and transmitter
	link_state_e st_q, st_d;
	logic [TW-1:0] tx_tick_q, tx_tick_d;
	bit_cnt_t tx_bit_q, tx_bit_d;
	bit_cnt_t sec_q, sec_d;
	logic bit_end;

	assign bit_end = i_osc_tick && (tx_tick_q == TICK_LAST);
	assign link_drive = (st_q == LINK_BRK_TX) || (st_q == LINK_HOLD) ||
		(st_q == LINK_ECHO);

	always_comb begin
		st_d = st_q;
		tx_tick_d = tx_tick_q;
		tx_bit_d = tx_bit_q;
		sec_d = sec_q;
		if (i_osc_tick) begin
			tx_tick_d = (tx_tick_q == TICK_LAST) ? '0 : tx_tick_q + 1'b1;
		end
		if (bit_end) begin
			tx_bit_d = tx_bit_q + 1'b1;
		end
		unique case (st_q)
			LINK_OFF: begin
				sec_d = 4'h0;
				if (mon_q && serial_q && i_ext_reset_n) begin
					st_d = LINK_SECURE;
				end
			end
			LINK_SECURE: begin
				if (rx_done_q) begin
					sec_d = sec_q + 1'b1;
					if (sec_q == `MON_SEC_LAST) begin
						st_d = LINK_BRK_TX;
						tx_tick_d = '0;
						tx_bit_d = 4'h0;
					end
				end
			end
			LINK_BRK_TX: begin
				if (bit_end && tx_bit_q == `MON_BREAK_LAST) begin
					st_d = LINK_READY;
				end
			end
			LINK_READY: begin
				if (rx_brk_q) begin
					st_d = LINK_HOLD;
					tx_tick_d = '0;
					tx_bit_d = 4'h0;
				end
			end
			LINK_HOLD: begin
				if (bit_end && tx_bit_q == `MON_HOLD_LAST) begin
					st_d = LINK_ECHO;
					tx_bit_d = 4'h0;
				end
			end
			LINK_ECHO: begin
				if (bit_end && tx_bit_q == `MON_BREAK_LAST) begin
					st_d = LINK_READY;
				end
			end
			default: begin
				st_d = LINK_OFF;
			end
		endcase
		// Any reset or mode loss restarts the security wait
		if (!mon_q || !serial_q || !i_ext_reset_n) begin
			st_d = LINK_OFF;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			st_q <= LINK_OFF;
			tx_tick_q <= '0;
			tx_bit_q <= 4'h0;
			sec_q <= 4'h0;
		end else if (i_clk_en) begin
			st_q <= st_d;
			tx_tick_q <= tx_tick_d;
			tx_bit_q <= tx_bit_d;
			sec_q <= sec_d;
		end
	end

	assign o_monitor_data_pin = (st_q == LINK_HOLD) || !link_drive;
	assign o_monitor_data_pin_oe = link_drive;
	assign o_link_ready = (st_q == LINK_READY);
	assign o_rx_data = rx_data_q;
	assign o_rx_valid = rx_done_q && (st_q == LINK_READY);
	assign o_break_seen = rx_brk_q && (st_q == LINK_READY);

endmodule

// ===== testbench/mon_host_model.sv
`timescale 1ns/1ps
module mon_host_model #(
	parameter int BIT_DIV = 1024
) (
	// Clock and line
	input wire logic i_sys_clk,
	output logic o_line
);
	// Released line sits at its pull-up level
	initial o_line = 1'b1;
	// Frame bit 0 first, then one idle bit before the next frame
	task send(input logic [9:0] frame);
		for (int i = 0; i < 10; i++) begin
			o_line = frame[i];
			repeat (BIT_DIV) @(negedge i_sys_clk);
		end
		o_line = 1'b1;
		repeat (BIT_DIV) @(negedge i_sys_clk);
	endtask
endmodule

// ===== testbench/monitor_entry_link_props.sv
`timescale 1ns/1ps
module monitor_entry_link_props #(
	parameter int BIT_DIV = 1024
) (
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire logic i_clk_en,
	input wire logic i_por,
	input wire logic i_ext_reset_n,
	input wire logic i_irq_test_high_voltage,
	input wire logic i_rst_test_high_voltage,
	input wire logic [7:0] i_reset_vector_hi,
	input wire logic [7:0] i_reset_vector_lo,
	input wire logic o_monitor_mode,
	input wire logic o_blank_entry,
	input wire logic o_watchdog_disable,
	input wire logic o_divider_bypass,
	input wire logic o_pll_enable,
	input wire logic o_bus_div4,
	input wire logic o_extra_reset,
	input wire logic [15:0] o_reset_vector_addr,
	input wire logic [15:0] o_break_vector_addr,
	input wire logic o_monitor_data_pin,
	input wire logic o_monitor_data_pin_oe,
	input wire logic o_break_seen,
	input wire logic o_rx_valid
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);
	// ==========================================================
	// Entry, vectors, watchdog, break echo
	reset_vec_a: assert property (
		o_reset_vector_addr == (o_monitor_mode ? 16'hFEFE : 16'hFFFE))
		else $error("reset vector address wrong");
	brk_vec_a: assert property (
		o_break_vector_addr == (o_monitor_mode ? 16'hFEFC : 16'hFFFC))
		else $error("break vector address wrong");
	latch_edge_a: assert property (
		i_clk_en && !i_por && !$rose(i_ext_reset_n) |=> $stable(o_monitor_mode))
		else $error("mode changed without reset rising edge");
	prog_user_a: assert property (
		i_clk_en && $rose(i_ext_reset_n) && !i_irq_test_high_voltage && !i_por
		&& !(o_monitor_mode && o_blank_entry)
		&& {i_reset_vector_hi, i_reset_vector_lo} != 16'hFFFF |=> !o_monitor_mode)
		else $error("programmed vector entered monitor without high voltage");
	blank_wd_a: assert property (
		o_monitor_mode && o_blank_entry && $past(o_monitor_mode && o_blank_entry)
		|-> o_watchdog_disable)
		else $error("watchdog enabled in blank monitor");
	hv_wd_a: assert property (
		i_clk_en && o_monitor_mode && !o_blank_entry && i_ext_reset_n
		&& !i_por && !$rose(i_ext_reset_n)
		|=> o_watchdog_disable == $past(i_irq_test_high_voltage || i_rst_test_high_voltage))
		else $error("watchdog does not follow test voltage");
	bypass_a: assert property (
		o_divider_bypass |-> o_monitor_mode && !o_blank_entry)
		else $error("divider bypass outside high-voltage entry");
	clk_src_a: assert property (
		o_pll_enable || o_bus_div4 |-> o_monitor_mode && o_blank_entry && !o_divider_bypass)
		else $error("pll or div4 outside blank entry");
	extra_rst_a: assert property (
		o_extra_reset |-> o_monitor_mode && o_blank_entry ##1 !o_extra_reset)
		else $error("extra reset pulse wrong");
	echo_hold_a: assert property (
		o_break_seen |-> ##[1:3] (o_monitor_data_pin_oe && o_monitor_data_pin)[*8])
		else $error("no high hold after break");
	cover property (o_extra_reset);
	cover property (o_rx_valid);
	cover property (o_break_seen);
endmodule

bind monitor_entry_link monitor_entry_link_props #(.BIT_DIV(BIT_DIV)) props (
	.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_clk_en(i_clk_en), .i_por(i_por),
	.i_ext_reset_n(i_ext_reset_n), .i_irq_test_high_voltage(i_irq_test_high_voltage),
	.i_rst_test_high_voltage(i_rst_test_high_voltage),
	.i_reset_vector_hi(i_reset_vector_hi), .i_reset_vector_lo(i_reset_vector_lo),
	.o_monitor_mode(o_monitor_mode), .o_blank_entry(o_blank_entry),
	.o_watchdog_disable(o_watchdog_disable), .o_divider_bypass(o_divider_bypass),
	.o_pll_enable(o_pll_enable), .o_bus_div4(o_bus_div4), .o_extra_reset(o_extra_reset),
	.o_reset_vector_addr(o_reset_vector_addr), .o_break_vector_addr(o_break_vector_addr),
	.o_monitor_data_pin(o_monitor_data_pin), .o_monitor_data_pin_oe(o_monitor_data_pin_oe),
	.o_break_seen(o_break_seen), .o_rx_valid(o_rx_valid));

// ===== testbench/monitor_entry_link_tb.sv
`timescale 1ns/1ps
module monitor_entry_link_tb;
	import mon_link_pkg::*;
	localparam int BD = 16;
	logic clk = 0, rst_n = 0, por = 1, ext_n = 0, ihv = 0, ilvl = 1, rhv = 0, en = 1;
	logic b0 = 0, b1 = 1, sel = 0, host;
	logic [7:0] vhi = 8'hFF, vlo = 8'hFF, rxd;
	logic mon, blank, ser, wd, byp, pll, div4, dout, oe, rdy, rxv, brk, xr;
	logic [15:0] rva, bva, sva;
	int xr_n = 0;
	wire pin = oe ? dout : host;
	int fails = 0, checked = 0, cycles = 0, hi_n = 0, lo_n = 0, rx_n = 0, brk_n = 0;
	always #2.5 clk = ~clk;
	monitor_entry_link #(.BIT_DIV(BD)) dut (.i_sys_clk(clk), .i_reset_n(rst_n),
		.i_clk_en(en), .i_por(por), .i_ext_reset_n(ext_n),
		.i_irq_test_high_voltage(ihv), .i_irq_level(ilvl), .i_rst_test_high_voltage(rhv),
		.i_port_b0(b0), .i_port_b1(b1), .i_comm_select_pin(sel),
		.i_reset_vector_hi(vhi), .i_reset_vector_lo(vlo), .i_osc_tick(1'b1),
		.o_monitor_mode(mon), .o_blank_entry(blank), .o_serial_mode(ser),
		.o_watchdog_disable(wd), .o_divider_bypass(byp), .o_pll_enable(pll),
		.o_bus_div4(div4), .o_extra_reset(xr), .o_reset_vector_addr(rva),
		.o_break_vector_addr(bva), .o_software_interrupt_vector_addr(sva),
		.i_monitor_data_pin(pin),
		.o_monitor_data_pin(dout), .o_monitor_data_pin_oe(oe), .o_link_ready(rdy),
		.o_rx_data(rxd), .o_rx_valid(rxv), .o_break_seen(brk));
	mon_host_model #(.BIT_DIV(BD)) host_m (.i_sys_clk(clk), .o_line(host));
	always @(posedge clk) begin
		cycles++;
		rx_n += rxv;
		brk_n += brk;
		xr_n += xr;
		if (oe) begin
			hi_n += dout;
			lo_n += !dout;
		end
		if (cycles == 30000) begin
			fails++;
			finish_test();
		end
	end
	task chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task finish_test;
		$display("checked=%0d fails=%0d", checked, fails);
		if (fails == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task pulse_reset;
		ext_n = 0;
		repeat (3) @(negedge clk);
		ext_n = 1;
		repeat (24) @(negedge clk);
	endtask
	task do_por;
		por = 1;
		@(negedge clk);
		por = 0;
	endtask
	// ==========================================================
	// Scenarios
	task t_blank;
		do_por();
		pulse_reset();
		chk(16'({mon, blank, ser, div4, pll, byp}), 16'h003C);
		chk(rva, 16'hFEFE);
		chk(bva, 16'hFEFC);
		chk(sva, 16'hFEFC);
		chk(16'(xr_n), 16'h0001);
		vhi = 8'h12;
		pulse_reset();
		chk(16'(mon), 16'h0001);
		lo_n = 0;
		hi_n = 0;
		for (int i = 0; i < 8; i++) host_m.send({1'b1, 8'h3C, 1'b0});
		repeat (12 * BD) @(negedge clk);
		chk(16'(lo_n > 9 * BD && lo_n <= 10 * BD && hi_n == 0), 16'h0001);
		chk(16'(rdy), 16'h0001);
		host_m.send({1'b1, 8'hA5, 1'b0});
		chk(16'(rx_n), 16'h0001);
		chk(16'(rxd), 16'h00A5);
		lo_n = 0;
		hi_n = 0;
		host_m.send(10'h000);
		repeat (13 * BD) @(negedge clk);
		chk(16'({rx_n[3:0], brk_n[3:0]}), 16'h0011);
		chk(16'(hi_n > BD && hi_n <= 2 * BD), 16'h0001);
		chk(16'(lo_n > 9 * BD && lo_n <= 10 * BD), 16'h0001);
		chk(16'(wd), 16'h0001);
		vhi = 8'hFF;
	endtask
	task t_ground;
		do_por();
		ilvl = 0;
		sel = 1;
		pulse_reset();
		chk(16'({mon, pll, div4, ser}), 16'h000C);
		chk(16'(xr_n), 16'h0002);
		ilvl = 1;
		sel = 0;
	endtask
	task t_hv;
		do_por();
		vhi = 8'h12;
		ihv = 1;
		b0 = 1;
		b1 = 0;
		pulse_reset();
		chk(16'({mon, blank, byp, wd}), 16'h000B);
		// Enable low must freeze the watchdog state
		en = 0;
		ihv = 0;
		repeat (2) @(negedge clk);
		chk(16'(wd), 16'h0001);
		en = 1;
		rhv = 1;
		ihv = 0;
		repeat (2) @(negedge clk);
		chk(16'(wd), 16'h0001);
		rhv = 0;
		repeat (2) @(negedge clk);
		chk(16'(wd), 16'h0000);
		pulse_reset();
		chk(16'(mon), 16'h0000);
		ihv = 1;
		b0 = 0;
		b1 = 1;
		pulse_reset();
		chk(16'(mon), 16'h0000);
		chk(sva, 16'hFFFC);
		ihv = 0;
		vhi = 8'hFF;
	endtask
	initial begin
		repeat (10) @(negedge clk);
		rst_n = 1;
		t_blank();
		t_ground();
		t_hv();
		finish_test();
	end
endmodule
